// >>> hdl/cld_detector.sv
// cold load pick-up detector with apb settings and status
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_detector #(
    parameter int unsigned CYCLE_CLKS = `CLD_CYCLE_CLKS
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire cld_pkg::cld_phase_type measured_magnitude,
    input  wire logic                   blocking_input,
    output logic                        pickup_active_output,
    output logic                        inhibited_output,
    output cld_pkg::cld_cond_type       function_condition_status,
    output cld_pkg::cld_event_type      status_event
);
    import cld_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // program cycle divider; eval follows tick so flags have settled
    logic [16:0] div_cnt;
    logic        tick;
    logic        eval;
    wire         div_end = (div_cnt == 17'(CYCLE_CLKS - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 17'h00000;
            tick    <= 1'b0;
            eval    <= 1'b0;
        end else begin
            div_cnt <= div_end ? 17'h00000 : div_cnt + 17'h00001;
            tick    <= div_end;
            eval    <= tick;
        end
    end

    // settings registers
    logic [3:0]  ctrl;
    logic [11:0] thr [3];
    logic [18:0] start_delay_time;
    logic [18:0] maximum_start_time;
    logic [18:0] minimum_hold_time;

    // apb decode
    wire setup    = psel && !penable;
    wire wr_en    = psel && penable && pwrite && pready;
    wire sel_ctrl = (paddr == `CLD_ADDR_CTRL);
    wire sel_low  = (paddr == `CLD_ADDR_LOW);
    wire sel_high = (paddr == `CLD_ADDR_HIGH);
    wire sel_over = (paddr == `CLD_ADDR_OVER);
    wire sel_start_delay_time = (paddr == `CLD_ADDR_START_DELAY_TIME);
    wire sel_maximum_start_time = (paddr == `CLD_ADDR_MAXIMUM_START_TIME);
    wire sel_minimum_hold_time = (paddr == `CLD_ADDR_MINIMUM_HOLD_TIME);
    wire sel_stat = (paddr == `CLD_ADDR_STAT);
    wire mapped   = sel_ctrl || sel_low || sel_high || sel_over ||
                    sel_start_delay_time || sel_maximum_start_time || sel_minimum_hold_time || sel_stat;

    // register writes; new values act from the next program cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= `CLD_RST_CTRL;
            thr[0] <= `CLD_RST_LOW;
            thr[1] <= `CLD_RST_HIGH;
            thr[2] <= `CLD_RST_OVER;
            start_delay_time   <= 19'(`CLD_RST_START_DELAY_TIME);
            maximum_start_time   <= 19'(`CLD_RST_MAXIMUM_START_TIME);
            minimum_hold_time   <= 19'(`CLD_RST_MINIMUM_HOLD_TIME);
        end else if (wr_en) begin
            if (sel_ctrl) begin
                ctrl <= pwdata[3:0];
            end else if (sel_low) begin
                thr[0] <= pwdata[11:0];
            end else if (sel_high) begin
                thr[1] <= pwdata[11:0];
            end else if (sel_over) begin
                thr[2] <= pwdata[11:0];
            end else if (sel_start_delay_time) begin
                start_delay_time <= pwdata[18:0];
            end else if (sel_maximum_start_time) begin
                maximum_start_time <= pwdata[18:0];
            end else if (sel_minimum_hold_time) begin
                minimum_hold_time <= pwdata[18:0];
            end
        end
    end

    // operating mode; without the individual mode bit the function runs on
    wire [2:0]    mode_bits = ctrl[`CLD_CTRL_MODE_MSB:`CLD_CTRL_MODE_LSB];
    wire          indiv     = ctrl[`CLD_CTRL_INDIV];
    cld_mode_type mode;
    assign mode = !indiv ? CLD_MODE_ON :
                  (mode_bits > 3'h4) ? CLD_MODE_OFF :
                  cld_mode_type'(mode_bits);
    wire       mode_off = (mode == CLD_MODE_OFF);
    wire       mode_blk = (mode == CLD_MODE_BLOCKED) ||
                          (mode == CLD_MODE_TEST_BLK);
    wire [2:0] mode_vis = indiv ? mode : 3'h0;

    // per phase, per threshold comparators with fixed release ratio
    wire [11:0] mag [3];
    wire [8:0]  exc;
    assign mag[0] = measured_magnitude.l1;
    assign mag[1] = measured_magnitude.l2;
    assign mag[2] = measured_magnitude.l3;
    for (genvar t = 0; t < 3; t++) begin : g_thr
        // one value for all phases, scaled once
        wire [19:0] thr_full = 20'(thr[t]) * `CLD_FULL_PCT;
        wire [19:0] thr_rel  = 20'(thr[t]) * `CLD_HYST_PCT;
        for (genvar p = 0; p < 3; p++) begin : g_ph
            wire [19:0] m = 20'(mag[p]) * `CLD_FULL_PCT;
            logic       hit;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hit <= 1'b0;
                end else if (tick) begin
                    if (m > thr_full) begin
                        hit <= 1'b1;
                    end else if (m <= thr_rel) begin
                        hit <= 1'b0;
                    end
                end
            end
            assign exc[t * 3 + p] = hit;
        end
    end

    // combined conditions
    wire low_cond  = ~|exc[2:0];
    wire high_cond = &exc[5:3];
    wire over_cond = |exc[8:6];

    // blocking is taken once per cycle so a mid-cycle edge cannot split it
    logic blk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_q <= 1'b0;
        end else if (tick) begin
            blk_q <= blocking_input || mode_blk;
        end
    end

    // sequence state and timers, counted in program cycles
    cld_state_type state;
    cld_state_type next_state;
    logic [18:0]   low_cnt;
    logic [18:0]   min_cnt;
    logic [18:0]   max_cnt;
    wire pick_fire  = low_cond && (low_cnt >= start_delay_time);
    wire min_done   = (min_cnt >= minimum_hold_time);
    wire max_done   = high_cond && (max_cnt >= maximum_start_time);
    wire start_over = !high_cond && !low_cond && min_done;

    // next state; overcurrent, block and maximum timer beat the hold time
    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (pick_fire) begin
                    next_state = blk_q ? ST_INHIBIT : ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (blk_q) begin
                    next_state = ST_WAIT;
                end else if (over_cond) begin
                    next_state = ST_WAIT;
                end else if (max_done) begin
                    next_state = ST_WAIT;
                end else if (start_over) begin
                    next_state = ST_WAIT;
                end
            end
            ST_INHIBIT: begin
                if (!low_cond) begin
                    next_state = ST_WAIT;
                end
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
        if (mode_off) begin
            next_state = ST_WAIT;
        end
    end

    // timers advance once per program cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_WAIT;
            low_cnt <= 19'h00000;
            min_cnt <= 19'h00000;
            max_cnt <= 19'h00000;
        end else if (eval) begin
            state   <= next_state;
            low_cnt <= (state == ST_WAIT && low_cond && !pick_fire) ?
                       low_cnt + 19'h00001 : 19'h00000;
            min_cnt <= (state != ST_ACTIVE) ? 19'h00000 :
                       min_done ? min_cnt : min_cnt + 19'h00001;
            max_cnt <= (state == ST_ACTIVE && high_cond) ?
                       max_cnt + 19'h00001 : 19'h00000;
        end
    end

    // outputs and condition status
    wire          next_act = (next_state == ST_ACTIVE);
    wire          next_inh = (next_state == ST_INHIBIT);
    cld_cond_type next_cond;
    assign next_cond = next_inh  ? COND_PICKUP_BLOCKED :
                       next_act  ? COND_PICKUP_ON :
                       over_cond ? COND_OVERCURRENT :
                       low_cond  ? COND_CURR_LOW : COND_NORMAL;

    // events last exactly one clock, only on a real change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pickup_active_output      <= 1'b0;
            inhibited_output          <= 1'b0;
            function_condition_status <= COND_NORMAL;
            status_event              <= '0;
        end else if (eval) begin
            pickup_active_output      <= next_act;
            inhibited_output          <= next_inh;
            function_condition_status <= next_cond;
            status_event <= '{
                pickup_on:   next_act && !pickup_active_output,
                pickup_off:  !next_act && pickup_active_output,
                inhibit_on:  next_inh && !inhibited_output,
                inhibit_off: !next_inh && inhibited_output
            };
        end else begin
            status_event <= '0;
        end
    end

    // status word
    wire [31:0] stat_word;
    assign stat_word[`CLD_STAT_ACT] = pickup_active_output;
    assign stat_word[`CLD_STAT_INH] = inhibited_output;
    assign stat_word[`CLD_STAT_COND_MSB:`CLD_STAT_COND_LSB] =
        function_condition_status;
    assign stat_word[`CLD_STAT_MODE_MSB:`CLD_STAT_MODE_LSB] = mode_vis;
    assign stat_word[`CLD_STAT_LOW]  = low_cond;
    assign stat_word[`CLD_STAT_HIGH] = high_cond;
    assign stat_word[`CLD_STAT_OVER] = over_cond;
    assign stat_word[`CLD_STAT_TOP:`CLD_STAT_OVER + 1] = 21'h000000;

    // read selection
    wire [31:0] rd_mux = sel_ctrl ? {28'h0000000, ctrl} :
                         sel_low  ? {20'h00000, thr[0]} :
                         sel_high ? {20'h00000, thr[1]} :
                         sel_over ? {20'h00000, thr[2]} :
                         sel_start_delay_time ? {13'h0000, start_delay_time} :
                         sel_maximum_start_time ? {13'h0000, maximum_start_time} :
                         sel_minimum_hold_time ? {13'h0000, minimum_hold_time} :
                         sel_stat ? stat_word : 32'h00000000;

    // apb answer: one access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
            pslverr <= setup && !mapped;
        end
    end

    // checks
    chk_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("program cycles too close");
    chk_block_sample: assert property (!tick |=> $stable(blk_q))
        else $error("blocking changed inside a cycle");
    chk_hyst_hold: assert property (
        tick && exc[0] && g_thr[0].g_ph[0].m > g_thr[0].thr_rel
        |=> exc[0])
        else $error("flag released above release level");
    chk_low_wait: assert property (
        eval && state == ST_WAIT && low_cnt < start_delay_time
        |=> !pickup_active_output)
        else $error("activated before start time");
    chk_pickup_set: assert property (
        eval && state == ST_WAIT && pick_fire && !blk_q && !mode_off
        |=> pickup_active_output && status_event.pickup_on)
        else $error("unblocked pick-up not activated");
    chk_block_inhibit: assert property (
        eval && state == ST_WAIT && pick_fire && blk_q && !mode_off
        |=> inhibited_output && !pickup_active_output)
        else $error("blocked pick-up not inhibited");
    chk_block_clear: assert property (
        eval && state == ST_ACTIVE && blk_q
        |=> !pickup_active_output && status_event.pickup_off)
        else $error("blocking did not clear output");
    chk_over_release: assert property (
        eval && state == ST_ACTIVE && over_cond |=> !pickup_active_output)
        else $error("overcurrent did not release");
    chk_max_release: assert property (
        eval && state == ST_ACTIVE && max_done |=> !pickup_active_output)
        else $error("maximum timer did not release");
    chk_min_hold: assert property (
        eval && state == ST_ACTIVE && !min_done && !blk_q && !over_cond
        && !max_done && !mode_off |=> pickup_active_output)
        else $error("output dropped before minimum time");
    chk_event_pair: assert property (
        $fell(pickup_active_output) |-> status_event.pickup_off
        ##1 !status_event.pickup_off)
        else $error("off event not a single pulse");

    cov_pickup: cover property ($rose(pickup_active_output));
    cov_inhibit: cover property ($rose(inhibited_output));
    cov_over: cover property (eval && state == ST_ACTIVE && over_cond);
    cov_max: cover property (eval && state == ST_ACTIVE && max_done);
endmodule

// >>> common/cld_cfg.svh
// register map, reset values and timing counts of the cold load detector
`ifndef CLD_CFG_SVH
`define CLD_CFG_SVH
// register byte addresses
`define CLD_ADDR_CTRL     12'h000
`define CLD_ADDR_LOW      12'h004
`define CLD_ADDR_HIGH     12'h008
`define CLD_ADDR_OVER     12'h00C
`define CLD_ADDR_START_DELAY_TIME     12'h010
`define CLD_ADDR_MAXIMUM_START_TIME     12'h014
`define CLD_ADDR_MINIMUM_HOLD_TIME     12'h018
`define CLD_ADDR_STAT     12'h01C
// control fields
`define CLD_CTRL_MODE_LSB 0
`define CLD_CTRL_MODE_MSB 2
`define CLD_CTRL_INDIV    3
// status fields
`define CLD_STAT_ACT      0
`define CLD_STAT_INH      1
`define CLD_STAT_COND_LSB 2
`define CLD_STAT_COND_MSB 4
`define CLD_STAT_MODE_LSB 5
`define CLD_STAT_MODE_MSB 7
`define CLD_STAT_LOW      8
`define CLD_STAT_HIGH     9
`define CLD_STAT_OVER     10
`define CLD_STAT_TOP      31
// thresholds in hundredths of nominal current
`define CLD_RST_CTRL      4'h0
`define CLD_RST_LOW       12'h014
`define CLD_RST_HIGH      12'h078
`define CLD_RST_OVER      12'h0C8
// percent figures for pick-up and release
`define CLD_FULL_PCT      20'h00064
`define CLD_HYST_PCT      20'h00061
// program cycle and timers, times in ms, timers in cycle steps
`define CLD_CYCLE_MS      5
`define CLD_PCLK_NS       50
`define CLD_CYCLE_CLKS    (`CLD_CYCLE_MS * 1000000 / `CLD_PCLK_NS)
`define CLD_START_DELAY_TIME_MS       10000
`define CLD_MAXIMUM_START_TIME_MS       30000
`define CLD_MINIMUM_HOLD_TIME_MS       40
`define CLD_RST_START_DELAY_TIME      (`CLD_START_DELAY_TIME_MS / `CLD_CYCLE_MS)
`define CLD_RST_MAXIMUM_START_TIME      (`CLD_MAXIMUM_START_TIME_MS / `CLD_CYCLE_MS)
`define CLD_RST_MINIMUM_HOLD_TIME      (`CLD_MINIMUM_HOLD_TIME_MS / `CLD_CYCLE_MS)
`endif

// >>> common/cld_pkg.sv
// types shared by the cold load detector
package cld_pkg;
    typedef enum logic [2:0] {
        CLD_MODE_ON, CLD_MODE_BLOCKED, CLD_MODE_TEST,
        CLD_MODE_TEST_BLK, CLD_MODE_OFF
    } cld_mode_type;
    typedef enum logic [2:0] {
        COND_NORMAL, COND_CURR_LOW, COND_OVERCURRENT,
        COND_PICKUP_ON, COND_PICKUP_BLOCKED
    } cld_cond_type;
    typedef enum logic [1:0] {
        ST_WAIT, ST_ACTIVE, ST_INHIBIT
    } cld_state_type;
    // phase magnitudes in hundredths of nominal current
    typedef struct packed {
        logic [11:0] l1;
        logic [11:0] l2;
        logic [11:0] l3;
    } cld_phase_type;
    // one-cycle transition pulses for event logging
    typedef struct packed {
        logic pickup_on;
        logic pickup_off;
        logic inhibit_on;
        logic inhibit_off;
    } cld_event_type;
endpackage

// >>> dv/cld_meas_model.sv
// phase current and blocking source standing in for measurement chain
`timescale 1ns/1ps
module cld_meas_model #(
    parameter int unsigned CYCLE_CLKS = 20
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire cld_pkg::cld_phase_type next_mag,
    input  wire logic                   next_block,
    output cld_pkg::cld_phase_type      measured_magnitude,
    output logic                        blocking_input
);
    import cld_pkg::*;

    int unsigned cnt;

    // refresh once per CYCLE_CLKS program cycle step, half a step away from the sampling tick
    // so a new value is always settled when the detector takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt                <= 0;
            measured_magnitude <= {12'h032, 12'h032, 12'h032};
            blocking_input     <= 1'b0;
        end else begin
            cnt <= (cnt == CYCLE_CLKS - 1) ? 0 : cnt + 1;
            if (cnt == CYCLE_CLKS / 2) begin
                measured_magnitude <= next_mag;
                blocking_input     <= next_block;
            end
        end
    end
endmodule

// >>> dv/cld_detector_tb_top.sv
// self-checking bench for the cold load pick-up detector
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_detector_tb_top;
    import cld_pkg::*;

    localparam int unsigned P     = 20;
    localparam int unsigned LIMIT = 20000;
    localparam logic [35:0] LOW3  = 36'h00A00A00A;
    localparam logic [35:0] MID3  = 36'h032032032;
    localparam logic [35:0] HIGH3 = 36'h096096096;
    localparam logic [11:0] RA [7] = '{`CLD_ADDR_CTRL, `CLD_ADDR_LOW,
        `CLD_ADDR_HIGH, `CLD_ADDR_OVER, `CLD_ADDR_START_DELAY_TIME, `CLD_ADDR_MAXIMUM_START_TIME,
        `CLD_ADDR_MINIMUM_HOLD_TIME};
    localparam logic [31:0] RV [7] = '{32'h0, 32'h14, 32'h78, 32'hC8,
        32'h7D0, 32'h1770, 32'h8};
    localparam logic [35:0] VM [8] = '{MID3, 36'h00A00A01E, HIGH3,
        36'h096096064, 36'h0C8032032, 36'h0C9032032, 36'h0C3032032,
        36'h0C2032032};
    localparam logic [2:0]  VF [8] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h0,
        3'h4, 3'h4, 3'h0};

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic [31:0]   rd;
    logic          pready;
    logic          pslverr;
    logic          err;
    logic          next_block;
    logic          blocking_input;
    logic          pickup_active_output;
    logic          inhibited_output;
    cld_phase_type next_mag;
    cld_phase_type measured_magnitude;
    cld_cond_type  function_condition_status;
    cld_event_type status_event;
    int            mismatches;
    int            num_checks;
    int            ons;
    int            offs;
    int            inh_ons;
    int            inh_offs;
    int            cycles;

    cld_detector #(.CYCLE_CLKS(P)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .measured_magnitude(measured_magnitude),
        .blocking_input(blocking_input),
        .pickup_active_output(pickup_active_output),
        .inhibited_output(inhibited_output),
        .function_condition_status(function_condition_status),
        .status_event(status_event));

    cld_meas_model #(.CYCLE_CLKS(P)) src (
        .pclk(pclk), .presetn(presetn), .next_mag(next_mag),
        .next_block(next_block), .measured_magnitude(measured_magnitude),
        .blocking_input(blocking_input));

    // free-running clock
    always #25 pclk = ~pclk;

    // hang guard and event pulse counting
    always @(posedge pclk) begin
        cycles++;
        if (status_event.pickup_on === 1'b1)
            ons++;
        if (status_event.pickup_off === 1'b1)
            offs++;
        if (status_event.inhibit_on === 1'b1)
            inh_ons++;
        if (status_event.inhibit_off === 1'b1)
            inh_offs++;
        if (cycles == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits for pready, no fixed latency assumed,
    // a hung slave is caught by the bench timeout, not here
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        xfer(1'b0, `CLD_ADDR_STAT, 32'h0);
        check(rd & mask, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n * P) @(posedge pclk);
    endtask

    task automatic wait_act(input logic v);
        int n;
        n = 0;
        while (pickup_active_output !== v && n < 30 * P) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        next_block = 1'b0;
        next_mag = MID3;
        mismatches = 0;
        num_checks = 0;
        ons = 0;
        offs = 0;
        inh_ons = 0;
        inh_offs = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, RA[i], 32'h0);
            check(rd, RV[i]);
        end
        xfer(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // short timers so every sequence fits the run
        xfer(1'b1, `CLD_ADDR_START_DELAY_TIME, 32'h3);
        xfer(1'b1, `CLD_ADDR_MAXIMUM_START_TIME, 32'h4);
        xfer(1'b1, `CLD_ADDR_MINIMUM_HOLD_TIME, 32'h2);
        // per-phase flags, shared thresholds, release at 97 percent
        for (int i = 0; i < 8; i++) begin
            next_mag <= VM[i];
            cyc(3);
            stat(32'h700, {21'h0, VF[i], 8'h0});
        end
        for (int m = 0; m < 5; m++) begin
            xfer(1'b1, `CLD_ADDR_CTRL, 32'h8 | m);
            cyc(2);
            stat(32'hE0, m << 5);
        end
        xfer(1'b1, `CLD_ADDR_CTRL, 32'h4);
        cyc(2);
        stat(32'hE0, 32'h0);
        xfer(1'b1, `CLD_ADDR_CTRL, 32'h0);
        // low current start delay, then plain release
        next_mag <= LOW3;
        cyc(2);
        check(pickup_active_output, 1'b0);
        check(function_condition_status, COND_CURR_LOW);
        stat(32'h100, 32'h100);
        wait_act(1'b1);
        check(pickup_active_output, 1'b1);
        check(function_condition_status, COND_PICKUP_ON);
        next_mag <= MID3;
        wait_act(1'b0);
        // overcurrent in one phase releases at once
        next_mag <= LOW3;
        wait_act(1'b1);
        next_mag <= 36'h00A0FA00A;
        cyc(3);
        check(pickup_active_output, 1'b0);
        check(function_condition_status, COND_OVERCURRENT);
        next_mag <= MID3;
        cyc(3);
        check(function_condition_status, COND_NORMAL);
        // high current held until the maximum timer runs out
        next_mag <= LOW3;
        wait_act(1'b1);
        next_mag <= HIGH3;
        cyc(2);
        check(pickup_active_output, 1'b1);
        cyc(6);
        check(pickup_active_output, 1'b0);
        next_mag <= MID3;
        cyc(3);
        // longer minimum hold, written while the sequence waits
        xfer(1'b1, `CLD_ADDR_MINIMUM_HOLD_TIME, 32'h6);
        next_mag <= LOW3;
        wait_act(1'b1);
        next_mag <= MID3;
        cyc(3);
        check(pickup_active_output, 1'b1);
        cyc(6);
        check(pickup_active_output, 1'b0);
        // blocked pick-up goes to the inhibited output only
        next_block <= 1'b1;
        next_mag <= LOW3;
        cyc(8);
        check(inhibited_output, 1'b1);
        check(pickup_active_output, 1'b0);
        check(function_condition_status, COND_PICKUP_BLOCKED);
        next_mag <= MID3;
        cyc(3);
        check(inhibited_output, 1'b0);
        // blocking arriving while active clears the output
        next_block <= 1'b0;
        next_mag <= LOW3;
        wait_act(1'b1);
        next_block <= 1'b1;
        cyc(3);
        check(pickup_active_output, 1'b0);
        next_mag <= MID3;
        next_block <= 1'b0;
        cyc(4);
        // mode off holds the sequence idle although currents stay low
        xfer(1'b1, `CLD_ADDR_CTRL, 32'hC);
        next_mag <= LOW3;
        cyc(8);
        check(pickup_active_output, 1'b0);
        check(function_condition_status, COND_CURR_LOW);
        next_mag <= MID3;
        cyc(3);
        xfer(1'b1, `CLD_ADDR_CTRL, 32'h0);
        cyc(2);
        check(pickup_active_output, 1'b0);
        check(ons, 5);
        check(offs, 5);
        check(inh_ons, 1);
        check(inh_offs, 1);
        report_and_stop();
    end
endmodule
